//--- design/sleep_clock_ctrl.sv
// sleep mode controller and per-peripheral clock gating
// Function
// RULE_01: sleep entered only when sleep enable set and sleep instruction runs
// RULE_02: bits 4:3 pick idle, noise reduction, power-down or standby
// RULE_03: after interrupt wake, core held four cycles beyond start-up time
// RULE_04: register file and static memory untouched across sleep
// RULE_05: reset during sleep wakes device and restarts from reset vector
// RULE_06: idle stops core and flash clocks only; any enabled interrupt wakes
// RULE_07: enabled converter starts a conversion on idle or noise entry
// RULE_08: noise reduction also stops I/O clock; converter clock keeps running
// RULE_09: noise reduction wake sources include conversion done and nvm ready
// RULE_10: power-down stops oscillator; only asynchronous wake sources remain
// RULE_11: standby like power-down but oscillator runs; wakes in six cycles
// RULE_12: deep modes wake on external interrupt zero level, never edge
// RULE_13: level wake signal must be held until the device wakes
// RULE_14: gated peripheral state frozen, its registers not accessible
// RULE_15: clearing gate bit restarts clock, peripheral resumes prior state
// RULE_16: gate bits 7..0: two-wire, serial b, serial a, spi, timers, converter
// RULE_17: software reinitialises spi after ungating
// RULE_18: software disables converter before gating it
// RULE_19: comparator unavailable while converter is gated
// RULE_20: input buffers off when I/O and converter clocks both stopped
// RULE_21: comparator disabled automatically in power-down and standby
// RULE_22: reserved sleep control bits 7:6 and 2 read as zero
// RULE_23: software sets sleep enable just before sleep, clears after wake
// RULE_24: power-down wake delay follows the selected start-up time
// RULE_25: after power-down wake, clocks held gated until start-up elapses
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

module sleep_clock_ctrl (
  // clock and reset
  input  wire logic                      CORE_CLK,
  input  wire logic                      RESET,
  // register port
  input  wire sleep_ctrl_pkg::reg_req_t  REG_REQ,
  output logic [7:0]                     REG_RDATA,
  // core side
  input  wire logic                      SLEEP_INSTR,
  input  wire logic                      CONVERTER_ENABLED,
  input  wire sleep_ctrl_pkg::wake_src_t WAKE_SRC,
  input  wire logic                      WAKE_RESET,
  // clock domains and peripherals
  output sleep_ctrl_pkg::domain_en_t     DOMAIN_EN,
  output logic [7:0]                     PERIPH_CLK_EN,
  output logic [7:0]                     PERIPH_ACCESS_EN,
  output logic                           CONV_START,
  output logic                           COMPARATOR_EN,
  output logic                           INPUT_BUFFER_EN,
  output logic                           CORE_HALT,
  output logic                           RESUME_IRQ,
  output logic                           RESTART_VECTOR
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]                  sleep_control;
    logic [7:0]                  clock_gate;
    logic [15:0]                 startup;
    sleep_ctrl_pkg::phase_t      phase;
    sleep_ctrl_pkg::sleep_mode_t mode;
    logic [15:0]                 count;
    logic                        by_reset;
    logic [7:0]                  rdata;
    sleep_ctrl_pkg::domain_en_t  domain;
    logic [7:0]                  clk_en;
    logic                        conv_start;
    logic                        comparator;
    logic                        inbuf;
    logic                        halt;
    logic                        resume;
    logic                        restart;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic   wake;

  ////////////////////////////////////////////////////////////////////////////
  // wake qualification per mode

  // deep modes only see asynchronous sources; edge on ext zero is ignored
  always_comb begin
    case (cur.mode)
      sleep_ctrl_pkg::MODE_IDLE: begin
        wake = WAKE_SRC.any_irq | WAKE_SRC.timer_irq        // RULE_06
             | WAKE_SRC.watchdog_irq | WAKE_SRC.ext0_level
             | WAKE_SRC.ext0_edge | WAKE_SRC.pin_change
             | WAKE_SRC.conv_done | WAKE_SRC.nvm_ready
             | WAKE_SRC.serial_start | WAKE_SRC.two_wire_match;
      end
      sleep_ctrl_pkg::MODE_NOISE: begin
        wake = WAKE_SRC.watchdog_irq | WAKE_SRC.ext0_level  // RULE_09
             | WAKE_SRC.pin_change | WAKE_SRC.conv_done
             | WAKE_SRC.nvm_ready | WAKE_SRC.serial_start
             | WAKE_SRC.two_wire_match;                     // RULE_12
      end
      default: begin
        wake = WAKE_SRC.watchdog_irq | WAKE_SRC.ext0_level  // RULE_10
             | WAKE_SRC.pin_change | WAKE_SRC.serial_start
             | WAKE_SRC.two_wire_match;                     // RULE_12
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cur            = cur;
    next_cur.conv_start = 1'b0;
    next_cur.resume     = 1'b0;
    next_cur.restart    = 1'b0;
    next_cur.rdata      = 8'h00;

    // register writes; the register file and memory are never touched here
    if (REG_REQ.write) begin                                // RULE_04
      if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_SLEEP_CONTROL) begin
        next_cur.sleep_control = REG_REQ.wdata
                               & sleep_ctrl_pkg::SLEEP_CONTROL_MASK;
      end else if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_CLOCK_GATE) begin
        next_cur.clock_gate = REG_REQ.wdata;                // RULE_16
      end else if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_STARTUP) begin
        next_cur.startup = {8'h00, REG_REQ.wdata};          // RULE_24
      end
    end

    // register reads; reserved bits are masked out at the write
    if (REG_REQ.read) begin
      if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_SLEEP_CONTROL) begin
        next_cur.rdata = cur.sleep_control;                 // RULE_22
      end else if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_CLOCK_GATE) begin
        next_cur.rdata = cur.clock_gate;
      end else if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_STATUS) begin
        next_cur.rdata = {4'h0, cur.mode, cur.phase};
      end else if (REG_REQ.addr == sleep_ctrl_pkg::ADDR_STARTUP) begin
        next_cur.rdata = cur.startup[7:0];
      end
    end

    // sleep sequencer
    case (cur.phase)
      sleep_ctrl_pkg::ST_RUN: begin
        if (SLEEP_INSTR
            && cur.sleep_control[sleep_ctrl_pkg::SLEEP_ENABLE_BIT]) begin
          next_cur.phase = sleep_ctrl_pkg::ST_SLEEP;        // RULE_01
          next_cur.mode  = sleep_ctrl_pkg::sleep_mode_t'(
            cur.sleep_control[sleep_ctrl_pkg::SELECT_HI:
                              sleep_ctrl_pkg::SELECT_LO]);  // RULE_02
          next_cur.conv_start = CONVERTER_ENABLED
            & ~cur.sleep_control[sleep_ctrl_pkg::SELECT_HI]; // RULE_07
        end
      end
      sleep_ctrl_pkg::ST_SLEEP: begin
        if (WAKE_RESET) begin
          next_cur.phase    = sleep_ctrl_pkg::ST_STARTUP;   // RULE_05
          next_cur.by_reset = 1'b1;
        end else if (wake) begin
          next_cur.phase    = sleep_ctrl_pkg::ST_STARTUP;
          next_cur.by_reset = 1'b0;
        end
        // start-up length depends on how deep the sleep was
        if (cur.mode == sleep_ctrl_pkg::MODE_POWER) begin
          next_cur.count = cur.startup;                     // RULE_25
        end else if (cur.mode == sleep_ctrl_pkg::MODE_STANDBY) begin
          // start-up spends count plus one cycles, so take one off here
          // to land on six cycles from wake sample to resume
          next_cur.count = sleep_ctrl_pkg::STANDBY_WAKE_CYCLES
                         - sleep_ctrl_pkg::HALT_EXTRA_CYCLES
                         - 16'h0001;                        // RULE_11
        end else begin
          next_cur.count = 16'h0000;
        end
      end
      sleep_ctrl_pkg::ST_STARTUP: begin
        if (cur.count == 16'h0000) begin
          if (cur.by_reset) begin
            next_cur.phase   = sleep_ctrl_pkg::ST_RUN;
            next_cur.restart = 1'b1;                        // RULE_05
          end else begin
            next_cur.phase = sleep_ctrl_pkg::ST_HALT;
            next_cur.count = sleep_ctrl_pkg::HALT_EXTRA_CYCLES
                           - 16'h0001;                      // RULE_03
          end
        end else begin
          next_cur.count = cur.count - 16'h0001;
        end
      end
      default: begin
        if (cur.count == 16'h0000) begin
          next_cur.phase  = sleep_ctrl_pkg::ST_RUN;
          next_cur.resume = 1'b1;                           // RULE_03
        end else begin
          next_cur.count = cur.count - 16'h0001;
        end
      end
    endcase

    // clock domain enables follow the phase of the next cycle
    next_cur.domain = '{cpu: 1'b1, flash: 1'b1, io: 1'b1,
                        conv: 1'b1, osc: 1'b1};
    next_cur.halt   = 1'b0;
    if (next_cur.phase != sleep_ctrl_pkg::ST_RUN) begin
      next_cur.halt         = 1'b1;
      next_cur.domain.cpu   = 1'b0;                         // RULE_06
      next_cur.domain.flash = 1'b0;
      if (next_cur.mode != sleep_ctrl_pkg::MODE_IDLE) begin
        next_cur.domain.io = 1'b0;                          // RULE_08
      end
      if (next_cur.mode[1]) begin
        next_cur.domain.conv = 1'b0;                        // RULE_10
        next_cur.domain.osc  = next_cur.mode[0]             // RULE_11
          | (next_cur.phase == sleep_ctrl_pkg::ST_STARTUP); // RULE_25
      end
    end
    // hold the halt window with core gated; io, converter and oscillator clocks run again
    if (next_cur.phase == sleep_ctrl_pkg::ST_HALT) begin
      next_cur.domain.io   = 1'b1;
      next_cur.domain.conv = 1'b1;
      next_cur.domain.osc  = 1'b1;
    end

    // comparator and input buffers in the deep modes
    next_cur.comparator = ~next_cur.clock_gate[sleep_ctrl_pkg::GATE_CONVERTER]
      & next_cur.domain.conv;                               // RULE_19 RULE_21
    next_cur.inbuf = next_cur.domain.io | next_cur.domain.conv; // RULE_20

    // peripheral clocks: gate bit or a stopped I/O clock freezes them; the converter follows its own domain
    next_cur.clk_en = ~next_cur.clock_gate
                    & {8{next_cur.domain.io}};              // RULE_14 RULE_15
    next_cur.clk_en[sleep_ctrl_pkg::GATE_CONVERTER] =
      ~next_cur.clock_gate[sleep_ctrl_pkg::GATE_CONVERTER]
      & next_cur.domain.conv;

    if (RESET) begin
      next_cur               = '0;
      next_cur.sleep_control = sleep_ctrl_pkg::RESET_SLEEP_CONTROL;
      next_cur.clock_gate    = sleep_ctrl_pkg::RESET_CLOCK_GATE;
      next_cur.startup       = sleep_ctrl_pkg::RESET_STARTUP;
      next_cur.phase         = sleep_ctrl_pkg::ST_RUN;
      next_cur.mode          = sleep_ctrl_pkg::MODE_IDLE;
      next_cur.domain        = '1;
      next_cur.clk_en        = '1;
      next_cur.comparator    = 1'b1;
      next_cur.inbuf         = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CORE_CLK) begin
    cur <= next_cur;
  end

  // all outputs come from flip-flops
  assign REG_RDATA        = cur.rdata;
  assign DOMAIN_EN        = cur.domain;
  assign PERIPH_CLK_EN    = cur.clk_en;
  assign PERIPH_ACCESS_EN = cur.clk_en;                     // RULE_14
  assign CONV_START       = cur.conv_start;
  assign COMPARATOR_EN    = cur.comparator;
  assign INPUT_BUFFER_EN  = cur.inbuf;
  assign CORE_HALT        = cur.halt;
  assign RESUME_IRQ       = cur.resume;
  assign RESTART_VECTOR   = cur.restart;

endmodule : sleep_clock_ctrl

//--- design/sleep_ctrl_pkg.sv
// shared constants and carrier types for the sleep and clock gating block
package sleep_ctrl_pkg;

  // register addresses on the plain register port
  localparam logic [3:0] ADDR_SLEEP_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_GATE    = 4'h1;
  localparam logic [3:0] ADDR_STATUS        = 4'h2;
  localparam logic [3:0] ADDR_STARTUP       = 4'h3;

  // sleep control field layout
  localparam int SLEEP_ENABLE_BIT = 5;
  localparam int SELECT_HI        = 4;
  localparam int SELECT_LO        = 3;
  localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h38;

  // peripheral gate bit positions
  localparam int GATE_TWO_WIRE  = 7;
  localparam int GATE_SERIAL_B  = 6;
  localparam int GATE_SERIAL_A  = 5;
  localparam int GATE_SPI       = 4;
  localparam int GATE_TIMER_C   = 3;
  localparam int GATE_TIMER_B   = 2;
  localparam int GATE_TIMER_A   = 1;
  localparam int GATE_CONVERTER = 0;

  // reset values
  localparam logic [7:0]  RESET_SLEEP_CONTROL = 8'h00;
  localparam logic [7:0]  RESET_CLOCK_GATE    = 8'h00;
  localparam logic [15:0] RESET_STARTUP       = 16'h0040;

  // timing: four halted cycles after start-up, six cycles standby wake
  localparam logic [15:0] HALT_EXTRA_CYCLES   = 16'h0004;
  localparam logic [15:0] STANDBY_WAKE_CYCLES = 16'h0006;

  // sleep modes as selected by the two-bit field
  typedef enum logic [1:0] {
    MODE_IDLE    = 2'b00,
    MODE_NOISE   = 2'b01,
    MODE_POWER   = 2'b10,
    MODE_STANDBY = 2'b11
  } sleep_mode_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HALT
  } phase_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_t;

  // wake event sources
  typedef struct packed {
    logic any_irq;
    logic timer_irq;
    logic watchdog_irq;
    logic ext0_level;
    logic ext0_edge;
    logic pin_change;
    logic conv_done;
    logic nvm_ready;
    logic serial_start;
    logic two_wire_match;
  } wake_src_t;

  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic osc;
  } domain_en_t;

endpackage : sleep_ctrl_pkg

//--- testbench/core_model.sv
// core side model: sleep instruction pulse and held wake levels
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // bench requests and block answer
  input  wire logic                      sleep_go,
  input  wire sleep_ctrl_pkg::wake_src_t wake_go,
  input  wire logic                      resumed,
  // toward the block
  output sleep_ctrl_pkg::wake_src_t      wake_src,
  output logic                           sleep_instr
);
  // a wake level stays up until the core is back, else it could be missed
  always @(posedge clk) begin
    if (rst || resumed)
      wake_src <= '0;
    else
      wake_src <= wake_src | wake_go;
    sleep_instr <= sleep_go & ~rst;
  end
endmodule : core_model

//--- testbench/sleep_clock_ctrl_assertions.sv
// port checks for the sleep and clock gating block
`timescale 1ns/1ps
module sleep_clock_ctrl_assertions (
  // clock, reset and register port
  input wire logic                       CORE_CLK,
  input wire logic                       RESET,
  input wire sleep_ctrl_pkg::reg_req_t   REG_REQ,
  input wire logic [7:0]                 REG_RDATA,
  // core side and domains
  input wire logic                       SLEEP_INSTR,
  input wire sleep_ctrl_pkg::domain_en_t DOMAIN_EN,
  input wire logic [7:0]                 PERIPH_CLK_EN,
  input wire logic [7:0]                 PERIPH_ACCESS_EN,
  input wire logic                       CONV_START,
  input wire logic                       COMPARATOR_EN,
  input wire logic                       INPUT_BUFFER_EN,
  input wire logic                       CORE_HALT,
  input wire logic                       RESUME_IRQ,
  input wire logic                       RESTART_VECTOR
);
  ////////////////////////////////////////////////////////////////////////////
  // one clock domain, so one default clocking and disable
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // entry and wake sequencing
  sleep_entry_a: assert property (
    $rose(CORE_HALT) |-> $past(SLEEP_INSTR)) else $error("halt without sleep");
  core_clocks_a: assert property (
    $rose(CORE_HALT) |-> !DOMAIN_EN.cpu && !DOMAIN_EN.flash)
    else $error("core clock running in sleep");
  conv_start_a: assert property (
    CONV_START |-> $rose(CORE_HALT) && DOMAIN_EN.conv ##1 !CONV_START)
    else $error("stray conversion start");
  halt_window_a: assert property (
    RESUME_IRQ |-> !CORE_HALT && $past(CORE_HALT) && $past(CORE_HALT, 4))
    else $error("halt window short");
  reset_restart_a: assert property (
    RESTART_VECTOR |-> $past(CORE_HALT) && !RESUME_IRQ)
    else $error("bad restart");
  // gating side effects
  buffer_off_a: assert property (
    !DOMAIN_EN.io && !DOMAIN_EN.conv |-> !INPUT_BUFFER_EN)
    else $error("input buffer on");
  comparator_off_a: assert property (
    !PERIPH_CLK_EN[0] || !DOMAIN_EN.conv |-> !COMPARATOR_EN)
    else $error("comparator on");
  access_block_a: assert property (
    PERIPH_ACCESS_EN == PERIPH_CLK_EN) else $error("access open");
  reserved_zero_a: assert property (
    REG_REQ.read && REG_REQ.addr == sleep_ctrl_pkg::ADDR_SLEEP_CONTROL |=>
    (REG_RDATA & 8'hC7) == 8'h00) else $error("reserved bits set");
  // main scenarios reached
  cover property (RESUME_IRQ);
  cover property (RESTART_VECTOR);
  cover property (CONV_START);
endmodule : sleep_clock_ctrl_assertions

//--- testbench/test_sleep_clock_ctrl.sv
// self-checking bench for the sleep and clock gating block
`timescale 1ns/1ps
module test_sleep_clock_ctrl;
  logic                       core_clk = 1'b0, reset = 1'b1;
  sleep_ctrl_pkg::reg_req_t   req = '0;
  logic [7:0]                 rdata, clk_en, acc_en, g;
  logic                       sleep_go = 1'b0, conv_on = 1'b1;
  logic                       wake_reset = 1'b0, sleep_instr;
  sleep_ctrl_pkg::wake_src_t  wake_go = '0, wake_src, w;
  sleep_ctrl_pkg::domain_en_t dom;
  logic                       conv_start, cmp_en, buf_en;
  logic                       halt, resume, restart;
  int                         error_cnt = 0, total_checks = 0, n;
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  sleep_clock_ctrl i_sleep_clock_ctrl (
    .CORE_CLK(core_clk), .RESET(reset), .REG_REQ(req), .REG_RDATA(rdata),
    .SLEEP_INSTR(sleep_instr), .CONVERTER_ENABLED(conv_on),
    .WAKE_SRC(wake_src), .WAKE_RESET(wake_reset), .DOMAIN_EN(dom),
    .PERIPH_CLK_EN(clk_en), .PERIPH_ACCESS_EN(acc_en),
    .CONV_START(conv_start), .COMPARATOR_EN(cmp_en),
    .INPUT_BUFFER_EN(buf_en), .CORE_HALT(halt), .RESUME_IRQ(resume),
    .RESTART_VECTOR(restart));
  core_model i_core_model (
    .clk(core_clk), .rst(reset), .sleep_go(sleep_go), .wake_go(wake_go),
    .resumed(resume | restart), .wake_src(wake_src),
    .sleep_instr(sleep_instr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD time %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // register port: strobe for one cycle, look just after the taking edge
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic r);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, write: !r, read: r};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b1);
    check(rdata, exp);
  endtask : rd
  // sleep instruction through the core model, then the entry state
  task automatic sleep_now(input int m, input logic en);
    @(posedge core_clk) sleep_go <= 1'b1;
    @(posedge core_clk) sleep_go <= 1'b0;
    @(posedge core_clk);
    #1 check(halt, en);
    if (en) begin
      check(dom, {2'b00, m == 0, m < 2, m != 2});
      check({conv_start, buf_en, cmp_en}, {3{m < 2}});
    end
  endtask : sleep_now
  // raise a wake, then count cycles to the resume, bounded
  task automatic wake(input sleep_ctrl_pkg::wake_src_t v);
    @(posedge core_clk) wake_go <= v;
    @(posedge core_clk) wake_go <= '0;
    n = 0;
    while (resume !== 1'b1 && restart !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 60) begin
      error_cnt++;
      test_done();
    end
  endtask : wake
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    #1 check({dom, cmp_en, buf_en, halt, clk_en}, {5'h1F, 3'b110, 8'hFF});
    rd(sleep_ctrl_pkg::ADDR_STARTUP, 8'h40);
    acc(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'hFF, 1'b0);
    rd(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'h38);
    rd(4'hF, 8'h00);
    // converter disabled before its gate bit is set
    @(posedge core_clk) conv_on <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      g = ~(8'h01 << i);
      acc(sleep_ctrl_pkg::ADDR_CLOCK_GATE, ~g, 1'b0);
      check(clk_en, g);
      check(acc_en, g);
      check(cmp_en, i != 0);
    end
    acc(sleep_ctrl_pkg::ADDR_CLOCK_GATE, 8'hA4, 1'b0);
    check(clk_en, 8'h5B);
    acc(sleep_ctrl_pkg::ADDR_STARTUP, 8'h10, 1'b0);
    @(posedge core_clk) conv_on <= 1'b1;
    acc(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'h18, 1'b0);
    sleep_now(3, 1'b0);
    // every mode: entry, refused edge wake except in idle, real wake, retained state
    for (int m = 0; m < 4; m++) begin
      acc(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'(32'h20 + m * 8), 1'b0);
      sleep_now(m, 1'b1);
      w = '0;
      if (m != 0) begin
        w.ext0_edge = 1'b1;
        @(posedge core_clk) wake_go <= w;
        @(posedge core_clk) wake_go <= '0;
        repeat (8) @(posedge core_clk);
        #1 check(halt, 1'b1);
      end
      w = '0;
      w.any_irq = (m == 0);
      w.ext0_level = (m != 0);
      wake(w);
      if (m == 2)
        check(n >= 20 && n <= 26, 1'b1);
      else
        check(n >= 5 && n <= 7, 1'b1);
      acc(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'h00, 1'b0);
      rd(sleep_ctrl_pkg::ADDR_CLOCK_GATE, 8'hA4);
    end
    // reset source during power-down goes to the reset vector
    acc(sleep_ctrl_pkg::ADDR_SLEEP_CONTROL, 8'h30, 1'b0);
    sleep_now(2, 1'b1);
    // status: power-down mode, sleep phase
    rd(sleep_ctrl_pkg::ADDR_STATUS, 8'h09);
    @(posedge core_clk) wake_reset <= 1'b1;
    wake('0);
    check({restart, resume}, 2'b10);
    test_done();
  end
endmodule : test_sleep_clock_ctrl
bind sleep_clock_ctrl sleep_clock_ctrl_assertions
  i_sleep_clock_ctrl_assertions (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .SLEEP_INSTR(SLEEP_INSTR), .DOMAIN_EN(DOMAIN_EN),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_ACCESS_EN(PERIPH_ACCESS_EN),
  .CONV_START(CONV_START), .COMPARATOR_EN(COMPARATOR_EN),
  .INPUT_BUFFER_EN(INPUT_BUFFER_EN), .CORE_HALT(CORE_HALT),
  .RESUME_IRQ(RESUME_IRQ), .RESTART_VECTOR(RESTART_VECTOR));
